// ===== hdl/txsir_pkg.sv
// Register map, field positions, timing constants and carrier types of the transmit status block.
package txsir_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register indices; the Wishbone byte address is four times the index.
   localparam logic [8:0] IDX_WMARK = 9'h187;
   localparam logic [8:0] IDX_EXPCTL = 9'h18A;
   localparam logic [8:0] IDX_SUPP = 9'h18B;
   localparam logic [8:0] IDX_SYNC = 9'h18E;
   localparam logic [8:0] IDX_LS1 = 9'h190;
   localparam logic [8:0] IDX_LS2 = 9'h191;
   localparam logic [8:0] IDX_LS3 = 9'h192;
   localparam logic [8:0] IDX_SUM = 9'h19F;
   localparam logic [8:0] IDX_MSK1 = 9'h1A0;
   localparam logic [8:0] IDX_MSK2 = 9'h1A1;
   localparam logic [8:0] IDX_MSK3 = 9'h1A2;
   localparam logic [8:0] IDX_MODE = 9'h1F8;

   // Reset value and writable-bit masks.
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] WMARK_BITS = 8'h03;
   localparam logic [7:0] EXPCTL_BITS = 8'h07;
   localparam logic [7:0] SYNC_BITS = 8'h0F;
   localparam logic [7:0] LS2_BITS = 8'h1F;
   localparam logic [7:0] LS3_BITS = 8'h01;
   localparam logic [7:0] MODE_BITS = 8'h0F;

   // Field positions.
   localparam int EXP_EN = 0;
   localparam int SC_RESYNC = 0;
   localparam int SC_AUTODIS = 1;
   localparam int SC_EN = 2;
   localparam int SC_CRC = 3;
   localparam int LS1_LOSS = 0;
   localparam int LS1_LOSSCLR = 1;
   localparam int LS1_MF = 2;
   localparam int LS1_ALIGN = 3;
   localparam int LS1_SLC = 4;
   localparam int LS1_SLIP = 5;
   localparam int LS1_EMPTY = 6;
   localparam int LS1_FULL = 7;
   localparam int LS2_NF = 0;
   localparam int LS2_LWM = 1;
   localparam int LS2_MEND = 2;
   localparam int LS2_UDR = 3;
   localparam int LS2_FDL = 4;
   localparam int LS3_LATCH = 0;
   localparam int LS3_LIVE = 1;
   localparam int MODE_E1 = 0;
   localparam int MODE_ESF = 1;
   localparam int MODE_SLC = 2;
   localparam int MODE_PIN = 3;

   // Packet FIFO depth and low watermark levels in bytes.
   localparam logic [6:0] FIFO_DEPTH = 7'h40;
   localparam logic [6:0] WM_LEVEL0 = 7'h04;
   localparam logic [6:0] WM_LEVEL1 = 7'h10;
   localparam logic [6:0] WM_LEVEL2 = 7'h20;
   localparam logic [6:0] WM_LEVEL3 = 7'h30;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing: frame-based periods and the transmit clock watchdog.
   localparam int FRAME_NS = 125000;
   localparam int ALIGN_NS = 250000;
   localparam int MF_D4_NS = 1500000;
   localparam int MF_ESF_NS = 3000000;
   localparam int MF_E1_NS = 2000000;
   localparam logic [6:0] SLC_FRAMES = 7'h48;
   localparam logic [6:0] ALIGN_FRAMES = 7'(ALIGN_NS / FRAME_NS);
   localparam logic [6:0] MF_D4_FRAMES = 7'(MF_D4_NS / FRAME_NS);
   localparam logic [6:0] MF_ESF_FRAMES = 7'(MF_ESF_NS / FRAME_NS);
   localparam logic [6:0] MF_E1_FRAMES = 7'(MF_E1_NS / FRAME_NS);
   localparam int CLK_PERIOD_NS = 20;
   localparam int TXCLK_PERIOD_NS = 648;
   localparam int LOSS_PERIODS = 3;
   localparam logic [6:0] LOSS_CYC =
      7'((LOSS_PERIODS * TXCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////////
   // Carrier types.
   typedef struct packed {
      logic esFullDelete;
      logic esEmptyRepeat;
      logic frameStart;
      logic fdlShiftedOut;
      logic fifoDrained;
      logic endMarked;
      logic messageDone;
      logic syncSearching;
      logic [6:0] fifoLevel;
   } txsir_events_t;

   typedef struct packed {
      logic enable;
      logic crcSearch;
      logic autoResync;
      logic resyncStart;
   } txsir_sync_ctl_t;

   typedef enum logic [1:0] {
      CLK_PRESENT = 2'b01,
      CLK_LOST = 2'b10
   } txsir_clk_state_t;

endpackage : txsir_pkg

// ===== hdl/txsir_regs.sv
// Transmit control, latched status, mask and interrupt logic behind a Wishbone slave.
//
// Notes on behaviour
// - Test pattern port is active only while expansion control bit 0 is one.
// - Suppress bit set removes that channel bit; bit 7 is channel bit 8.
// - CRC-4 multiframe search runs in E1 mode only when control bit 3 is one.
// - Synchronizer runs only while control bit 2 is one.
// - Control bit 1 zero means auto resync on; one means auto resync off.
// - Rising edge of control bit 0 starts one resync; host toggles for more.
// - First latched status bits hold until host clears; each can interrupt.
// - Bit 7 sets on elastic store full delete, bit 6 on empty repeat.
// - Bit 5 sets on any elastic store slip.
// - T1, when enabled: bit 4 sets once per 72-frame SLC-96 multiframe.
// - E1: bit 3 sets every 250 us for align-frame updates.
// - Bit 2 sets per multiframe: 1.5 ms D4, 3 ms ESF, 2 ms E1.
// - Bit 0 sets after ~3 idle transmit clock periods; bit 1 when clock returns.
// - Loss bit clearable while loss persists; loss pin stays high meanwhile.
// - Interrupt goes low on unmasked set, high when nothing unmasked remains.
// - T1: packet status bit 4 sets when data link register shifted 8 bits.
// - Bit 3 sets on FIFO underrun and sends abort; bit 2 on message end.
// - Bit 1 sets on rising edge of FIFO below low watermark.
// - Bit 0 sets on rising edge of FIFO not full.
// - Sync status bit 1 is live searching; bit 0 latches searching.
// - Summary register shows live pending state of each latched register.
// - First mask bit one lets the matching status bit interrupt.
// - Watermark select 00/01/10/11 means 4/16/32/48 bytes.
// - Packet mask register gates its status bits one for one; sync mask bit 0 gates only sync status bit 0.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none

module txsir_regs (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Wishbone classic slave.
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [10:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatIn,
   output logic [31:0] wbDatOut,
   output logic wbAck,
   // Events and levels from the transmit datapath.
   input wire txsir_pkg::txsir_events_t txEvents,
   input wire logic txLineClockIn,
   // Control and status outputs.
   output var txsir_pkg::txsir_sync_ctl_t syncCtl,
   output logic testPortActive,
   output logic [7:0] testPortBitUse,
   output logic sendAbort,
   output logic clockLossPin,
   output logic intN
);
   import txsir_pkg::*;

   logic wbAck_q;
   logic [7:0] rdData_q;
   logic [7:0] rdByte;
   logic reqValid;
   logic wrEn;
   logic [8:0] regIdx;
   logic [7:0] wrData;
   logic [7:0] wmark_q;
   logic [7:0] expCtl_q;
   logic [7:0] supp_q;
   logic [7:0] syncCtrl_q;
   logic [7:0] mode_q;
   logic [7:0] msk1_q;
   logic [7:0] msk2_q;
   logic [7:0] msk3_q;
   logic [7:0] ls1_q;
   logic [7:0] ls2_q;
   logic [7:0] ls3_q;
   logic [7:0] ls1Set;
   logic [7:0] ls2Set;
   logic [7:0] ls3Set;
   logic [7:0] ls1_d;
   logic [7:0] ls2_d;
   logic [7:0] ls3_d;
   logic pend1;
   logic pend2;
   logic pend3;
   logic intN_q;
   logic isE1;
   logic [6:0] mfCnt_q;
   logic [6:0] slcCnt_q;
   logic [6:0] alignCnt_q;
   logic [6:0] mfLen;
   logic mfWrap;
   logic slcWrap;
   logic alignWrap;
   logic txClkMeta_q;
   logic txClkSync_q;
   logic txClkPrev_q;
   logic txClkEdge;
   logic [6:0] idleCnt_q;
   txsir_clk_state_t clkState_q;
   logic lostPrev_q;
   logic lossRose;
   logic lossFell;
   logic clockLossPin_q;
   logic [6:0] wmLevel;
   logic belowMark;
   logic notFull;
   logic belowPrev_q;
   logic notFullPrev_q;
   logic underrun;
   logic sendAbort_q;
   logic syncLive;
   logic resyncPrev_q;
   txsir_sync_ctl_t syncCtl_q;
   logic [7:0] testPortBitUse_q;
   logic testPortActive_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode. Only byte lane 0 carries register data; other lanes are ignored.
   assign reqValid = wbCyc & wbStb & ~wbAck_q;
   assign wrEn = reqValid & wbWe & wbSel[0];
   assign regIdx = wbAdr[10:2];
   assign wrData = wbDatIn[7:0];
   assign isE1 = mode_q[MODE_E1];

   // Ack one cycle after the request; gating with ack makes it a single pulse.
   always_ff @(posedge clk) begin
      if (rst) begin
         wbAck_q <= 1'b0;
      end else begin
         wbAck_q <= reqValid;
      end
   end

   // Read data is captured with the ack; unmapped indices read as zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_q <= REG_RESET;
      end else if (reqValid && !wbWe) begin
         rdData_q <= rdByte;
      end
   end

   // Read multiplexer; the summary register is live, not stored.
   always_comb begin
      rdByte = REG_RESET;
      case (regIdx)
         IDX_WMARK: rdByte = wmark_q;
         IDX_EXPCTL: rdByte = expCtl_q;
         IDX_SUPP: rdByte = supp_q;
         IDX_SYNC: rdByte = syncCtrl_q;
         IDX_LS1: rdByte = ls1_q;
         IDX_LS2: rdByte = ls2_q;
         IDX_LS3: rdByte = ls3_q;
         IDX_SUM: rdByte = {5'h00, pend3, pend2, pend1};
         IDX_MSK1: rdByte = msk1_q;
         IDX_MSK2: rdByte = msk2_q;
         IDX_MSK3: rdByte = msk3_q;
         IDX_MODE: rdByte = mode_q;
         default: rdByte = REG_RESET;
      endcase
   end

   assign wbAck = wbAck_q;
   assign wbDatOut = {24'h000000, rdData_q};

   ////////////////////////////////////////////////////////////////////////////////
   // Plain read/write control registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         wmark_q <= REG_RESET;
         expCtl_q <= REG_RESET;
         supp_q <= REG_RESET;
         syncCtrl_q <= REG_RESET;
         mode_q <= REG_RESET;
         msk1_q <= REG_RESET;
         msk2_q <= REG_RESET;
         msk3_q <= REG_RESET;
      end else if (wrEn) begin
         case (regIdx)
            IDX_WMARK: wmark_q <= wrData & WMARK_BITS;
            IDX_EXPCTL: expCtl_q <= wrData & EXPCTL_BITS;
            IDX_SUPP: supp_q <= wrData;
            IDX_SYNC: syncCtrl_q <= wrData & SYNC_BITS;
            IDX_MODE: mode_q <= wrData & MODE_BITS;
            IDX_MSK1: msk1_q <= wrData;
            IDX_MSK2: msk2_q <= wrData & LS2_BITS;
            IDX_MSK3: msk3_q <= wrData & LS3_BITS;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test pattern port: enable and per-bit suppress, bit n of the mask is channel bit n+1.
   always_ff @(posedge clk) begin
      if (rst) begin
         testPortActive_q <= 1'b0;
         testPortBitUse_q <= REG_RESET;
      end else begin
         testPortActive_q <= expCtl_q[EXP_EN];
         testPortBitUse_q <= expCtl_q[EXP_EN] ? ~supp_q : REG_RESET;
      end
   end

   assign testPortActive = testPortActive_q;
   assign testPortBitUse = testPortBitUse_q;

   a_test_port_off: assert property (@(posedge clk) disable iff (rst)
      !expCtl_q[EXP_EN] |=> (testPortBitUse == 8'h00 && !testPortActive))
      else $error("Test port used while disabled.");

   a_suppress_map: assert property (@(posedge clk) disable iff (rst)
      expCtl_q[EXP_EN] |=> (testPortBitUse == ~$past(supp_q)))
      else $error("Suppress mask not applied bit for bit.");

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronizer control. The resync strobe only fires while the synchronizer runs.
   always_ff @(posedge clk) begin
      if (rst) begin
         resyncPrev_q <= 1'b0;
         syncCtl_q <= '0;
      end else begin
         resyncPrev_q <= syncCtrl_q[SC_RESYNC];
         syncCtl_q.enable <= syncCtrl_q[SC_EN];
         syncCtl_q.crcSearch <= syncCtrl_q[SC_CRC] & syncCtrl_q[SC_EN] & isE1;
         syncCtl_q.autoResync <= ~syncCtrl_q[SC_AUTODIS] & syncCtrl_q[SC_EN];
         syncCtl_q.resyncStart <= syncCtrl_q[SC_RESYNC] & ~resyncPrev_q & syncCtrl_q[SC_EN];
      end
   end

   assign syncCtl = syncCtl_q;

   a_resync_edge: assert property (@(posedge clk) disable iff (rst)
      ($rose(syncCtrl_q[SC_RESYNC]) && syncCtrl_q[SC_EN]) |=> syncCtl.resyncStart ##1 !syncCtl.resyncStart)
      else $error("Resync strobe missing or longer than one cycle.");

   a_crc_gate: assert property (@(posedge clk) disable iff (rst)
      syncCtl.crcSearch |-> $past(isE1 && syncCtrl_q[SC_CRC] && syncCtrl_q[SC_EN]))
      else $error("CRC-4 search active outside E1 or without its bit.");

   ////////////////////////////////////////////////////////////////////////////////
   // Frame counters for the periodic status events.
   always_comb begin
      mfLen = MF_D4_FRAMES;
      if (isE1) begin
         mfLen = MF_E1_FRAMES;
      end else if (mode_q[MODE_ESF]) begin
         mfLen = MF_ESF_FRAMES;
      end
   end

   assign mfWrap = txEvents.frameStart & (mfCnt_q >= mfLen - 7'h01);
   assign slcWrap = txEvents.frameStart & (slcCnt_q >= SLC_FRAMES - 7'h01);
   assign alignWrap = txEvents.frameStart & (alignCnt_q >= ALIGN_FRAMES - 7'h01);

   always_ff @(posedge clk) begin
      if (rst) begin
         mfCnt_q <= 7'h00;
         slcCnt_q <= 7'h00;
         alignCnt_q <= 7'h00;
      end else if (txEvents.frameStart) begin
         mfCnt_q <= mfWrap ? 7'h00 : mfCnt_q + 7'h01;
         slcCnt_q <= slcWrap ? 7'h00 : slcCnt_q + 7'h01;
         alignCnt_q <= alignWrap ? 7'h00 : alignCnt_q + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit clock watchdog. The pin is synchronised; edges are taken from the second and third stages.
   always_ff @(posedge clk) begin
      if (rst) begin
         txClkMeta_q <= 1'b0;
         txClkSync_q <= 1'b0;
         txClkPrev_q <= 1'b0;
      end else begin
         txClkMeta_q <= txLineClockIn;
         txClkSync_q <= txClkMeta_q;
         txClkPrev_q <= txClkSync_q;
      end
   end

   assign txClkEdge = txClkSync_q ^ txClkPrev_q;

   // Idle counter saturates at the loss threshold, so it cannot wrap back to present.
   always_ff @(posedge clk) begin
      if (rst) begin
         idleCnt_q <= 7'h00;
         clkState_q <= CLK_PRESENT;
      end else begin
         if (txClkEdge) begin
            idleCnt_q <= 7'h00;
         end else if (idleCnt_q != LOSS_CYC) begin
            idleCnt_q <= idleCnt_q + 7'h01;
         end
         case (clkState_q)
            CLK_PRESENT: begin
               if (!txClkEdge && idleCnt_q == LOSS_CYC - 7'h01) begin
                  clkState_q <= CLK_LOST;
               end
            end
            CLK_LOST: begin
               if (txClkEdge) begin
                  clkState_q <= CLK_PRESENT;
               end
            end
            default: clkState_q <= CLK_PRESENT;
         endcase
      end
   end

   // The pin follows the live condition, independent of the latched bit.
   always_ff @(posedge clk) begin
      if (rst) begin
         lostPrev_q <= 1'b0;
         clockLossPin_q <= 1'b0;
      end else begin
         lostPrev_q <= (clkState_q == CLK_LOST);
         clockLossPin_q <= (clkState_q == CLK_LOST) & mode_q[MODE_PIN];
      end
   end

   assign lossRose = (clkState_q == CLK_LOST) & ~lostPrev_q;
   assign lossFell = (clkState_q == CLK_PRESENT) & lostPrev_q;
   assign clockLossPin = clockLossPin_q;

   a_loss_timeout: assert property (@(posedge clk) disable iff (rst)
      (clkState_q == CLK_PRESENT && !txClkEdge && idleCnt_q == LOSS_CYC - 7'h01) |=> ##1 ls1_q[LS1_LOSS])
      else $error("Loss of transmit clock not latched after timeout.");

   a_loss_pin: assert property (@(posedge clk) disable iff (rst)
      (clkState_q == CLK_LOST && mode_q[MODE_PIN]) |=> clockLossPin)
      else $error("Loss pin low while clock still lost.");

   ////////////////////////////////////////////////////////////////////////////////
   // Packet FIFO levels and underrun handling.
   always_comb begin
      case (wmark_q[1:0])
         2'h0: wmLevel = WM_LEVEL0;
         2'h1: wmLevel = WM_LEVEL1;
         2'h2: wmLevel = WM_LEVEL2;
         2'h3: wmLevel = WM_LEVEL3;
         default: wmLevel = WM_LEVEL0;
      endcase
   end

   assign belowMark = txEvents.fifoLevel < wmLevel;
   assign notFull = txEvents.fifoLevel < FIFO_DEPTH;
   assign underrun = txEvents.fifoDrained & ~txEvents.endMarked;

   // Previous levels reset high: an empty FIFO after reset is no new edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         belowPrev_q <= 1'b1;
         notFullPrev_q <= 1'b1;
         sendAbort_q <= 1'b0;
      end else begin
         belowPrev_q <= belowMark;
         notFullPrev_q <= notFull;
         sendAbort_q <= underrun;
      end
   end

   assign sendAbort = sendAbort_q;
   assign syncLive = txEvents.syncSearching & syncCtrl_q[SC_EN];

   ////////////////////////////////////////////////////////////////////////////////
   // Set terms of the latched status registers.
   always_comb begin
      ls1Set = 8'h00;
      ls1Set[LS1_FULL] = txEvents.esFullDelete;
      ls1Set[LS1_EMPTY] = txEvents.esEmptyRepeat;
      ls1Set[LS1_SLIP] = txEvents.esFullDelete | txEvents.esEmptyRepeat;
      ls1Set[LS1_SLC] = ~isE1 & mode_q[MODE_SLC] & slcWrap;
      ls1Set[LS1_ALIGN] = isE1 & alignWrap;
      ls1Set[LS1_MF] = mfWrap;
      ls1Set[LS1_LOSSCLR] = lossFell;
      ls1Set[LS1_LOSS] = lossRose;
      ls2Set = 8'h00;
      ls2Set[LS2_FDL] = ~isE1 & txEvents.fdlShiftedOut;
      ls2Set[LS2_UDR] = underrun;
      ls2Set[LS2_MEND] = txEvents.messageDone;
      ls2Set[LS2_LWM] = belowMark & ~belowPrev_q;
      ls2Set[LS2_NF] = notFull & ~notFullPrev_q;
      ls3Set = 8'h00;
      ls3Set[LS3_LATCH] = syncLive;
   end

   // Write-one-to-clear with the set term taking priority over the clear.
   always_comb begin
      ls1_d = ls1_q;
      ls2_d = ls2_q;
      ls3_d = ls3_q;
      if (wrEn && regIdx == IDX_LS1) begin
         ls1_d = ls1_q & ~wrData;
      end
      if (wrEn && regIdx == IDX_LS2) begin
         ls2_d = ls2_q & ~wrData;
      end
      if (wrEn && regIdx == IDX_LS3) begin
         ls3_d = ls3_q & ~wrData;
      end
      ls1_d = ls1_d | ls1Set;
      ls2_d = (ls2_d | ls2Set) & LS2_BITS;
      ls3_d = ((ls3_d | ls3Set) & LS3_BITS) | {6'h00, syncLive, 1'b0};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ls1_q <= REG_RESET;
         ls2_q <= REG_RESET;
         ls3_q <= REG_RESET;
      end else begin
         ls1_q <= ls1_d;
         ls2_q <= ls2_d;
         ls3_q <= ls3_d;
      end
   end

   a_ls1_set_wins: assert property (@(posedge clk) disable iff (rst)
      (|ls1Set) |=> ((ls1_q & $past(ls1Set)) == $past(ls1Set)))
      else $error("Latched event lost.");

   a_ls1_w1c: assert property (@(posedge clk) disable iff (rst)
      (wrEn && regIdx == IDX_LS1) |=> ((ls1_q & $past(wrData & ~ls1Set)) == 8'h00))
      else $error("Write of one did not clear latched bit.");

   a_ls1_holds: assert property (@(posedge clk) disable iff (rst)
      (!(wrEn && regIdx == IDX_LS1)) |=> ((ls1_q & $past(ls1_q)) == $past(ls1_q)))
      else $error("Latched bit dropped without a clear.");

   a_mf_boundary: assert property (@(posedge clk) disable iff (rst)
      mfWrap |=> ls1_q[LS1_MF])
      else $error("Multiframe boundary not latched.");

   a_nf_edge: assert property (@(posedge clk) disable iff (rst)
      (notFull && !notFullPrev_q) |=> ls2_q[LS2_NF])
      else $error("Not-full edge not latched.");

   ////////////////////////////////////////////////////////////////////////////////
   // Masking, summary and the active-low interrupt output.
   assign pend1 = |(ls1_q & msk1_q);
   assign pend2 = |(ls2_q & msk2_q);
   assign pend3 = |(ls3_q & msk3_q & LS3_BITS);

   always_ff @(posedge clk) begin
      if (rst) begin
         intN_q <= 1'b1;
      end else begin
         intN_q <= ~(pend1 | pend2 | pend3);
      end
   end

   assign intN = intN_q;

   a_int_low: assert property (@(posedge clk) disable iff (rst)
      (pend1 || pend2 || pend3) |=> !intN)
      else $error("Interrupt not asserted for unmasked status.");

   a_int_high: assert property (@(posedge clk) disable iff (rst)
      (((ls1_q & msk1_q) == 8'h00) && !pend2 && !pend3) |=> intN)
      else $error("Interrupt asserted with all sources masked or clear.");

endmodule : txsir_regs

`default_nettype wire

// ===== sim/txsir_host.sv
// Host model: a classic Wishbone master that runs single register cycles.
`timescale 1ns/1ps
`default_nettype none
module txsir_host (
   // Clock.
   input wire logic clk,
   // Wishbone master side.
   output logic wbCyc,
   output logic wbStb,
   output logic wbWe,
   output logic [10:0] wbAdr,
   output logic [3:0] wbSel,
   output logic [31:0] wbDatIn,
   input wire logic [31:0] wbDatOut,
   input wire logic wbAck
);
   // Bus idle at time zero.
   initial begin
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn} = '0;
   end

   // Holds the request until ack is sampled, so the slave decides the latency.
   task automatic xfer(input logic w, input logic [8:0] idx, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      {wbCyc, wbStb, wbWe, wbSel} <= {1'b1, 1'b1, w, 4'h1};
      wbAdr <= {idx, 2'b00};
      wbDatIn <= {24'h000000, d};
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbDatOut[7:0];
      {wbCyc, wbStb, wbWe} <= 3'h0;
      if (wbAck !== 1'b1) begin
         tx_status_interrupt_regs_tb.n_mismatch++;
         tx_status_interrupt_regs_tb.print_verdict();
      end
   endtask : xfer
endmodule : txsir_host
`default_nettype wire

// ===== sim/tx_status_interrupt_regs_tb.sv
// Self-checking bench for the transmit status and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tx_status_interrupt_regs_tb;
   import txsir_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic lineClk = 1'b0;
   logic run = 1'b1;
   logic [3:0] tick = 4'h0;
   logic [7:0] q;
   int n_mismatch = 0;
   int checked = 0;
   int nRes = 0;
   int nAbort = 0;
   txsir_events_t ev = '0;
   txsir_sync_ctl_t syncCtl;
   logic cyc, stb, we, ack, tpa, abt, pin, intN;
   logic [3:0] sel;
   logic [10:0] adr;
   logic [31:0] dw, dr;
   logic [7:0] use8;
   logic [6:0] thr[4] = '{WM_LEVEL0, WM_LEVEL1, WM_LEVEL2, WM_LEVEL3};
   logic [8:0] ix[5] = '{IDX_SUPP, IDX_SYNC, IDX_LS2, IDX_SUM, IDX_MSK1};

   ////////////////////////////////////////////////////////////////////////////////
   // System clock at 50 MHz.
   always #10 clk = ~clk;

   // Line clock toggles every 16 cycles while running, well inside the loss window.
   always @(posedge clk) begin
      tick <= tick + 4'h1;
      if (run && tick == 4'h0) lineClk <= ~lineClk;
      if (syncCtl.resyncStart === 1'b1) nRes <= nRes + 1;
      if (abt === 1'b1) nAbort <= nAbort + 1;
   end

   txsir_regs u_txsir_regs (.clk(clk), .rst(rst), .wbCyc(cyc), .wbStb(stb), .wbWe(we), .wbAdr(adr),
      .wbSel(sel), .wbDatIn(dw), .wbDatOut(dr), .wbAck(ack), .txEvents(ev), .txLineClockIn(lineClk),
      .syncCtl(syncCtl), .testPortActive(tpa), .testPortBitUse(use8), .sendAbort(abt),
      .clockLossPin(pin), .intN(intN));
   txsir_host u_txsir_host (.clk(clk), .wbCyc(cyc), .wbStb(stb), .wbWe(we), .wbAdr(adr), .wbSel(sel),
      .wbDatIn(dw), .wbDatOut(dr), .wbAck(ack));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count.
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rd(input logic [8:0] idx, input logic [7:0] exp, input string nm);
      u_txsir_host.xfer(1'b0, idx, 8'h00, q);
      chk(nm, q, exp);
   endtask : rd
   // Two extra cycles let registered outputs follow the write.
   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      u_txsir_host.xfer(1'b1, idx, d, q);
      repeat (2) @(posedge clk);
   endtask : wr
   // Event mask bits: 4000 full, 2000 empty, 1000 frame, 0400 drained, 0100 done.
   task automatic pulse(input logic [14:0] m, input int n);
      repeat (n) begin
         @(posedge clk) ev <= ev | m;
         @(posedge clk) ev <= ev & ~m;
      end
      repeat (3) @(posedge clk);
   endtask : pulse
   task automatic print_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (ix[i]) rd(ix[i], REG_RESET, "reset");
      rd(9'h1FF, 8'h00, "unmapped");
      wr(IDX_EXPCTL, 8'h01);
      wr(IDX_SUPP, 8'hA5);
      chk("active", {7'h00, tpa}, 8'h01);
      chk("bituse", use8, 8'h5A);
      wr(IDX_EXPCTL, 8'h00);
      chk("bitoff", use8, 8'h00);
      wr(IDX_MODE, 8'h01);
      wr(IDX_SYNC, 8'h0C);
      chk("sync", {4'h0, syncCtl}, 8'h0E);
      wr(IDX_SYNC, 8'h06);
      chk("sync", {4'h0, syncCtl}, 8'h08);
      wr(IDX_SYNC, 8'h07);
      wr(IDX_SYNC, 8'h07);
      wr(IDX_SYNC, 8'h06);
      wr(IDX_SYNC, 8'h07);
      chk("resync", 8'(nRes), 8'h02);
      wr(IDX_SYNC, 8'h0A);
      wr(IDX_SYNC, 8'h0B);
      chk("sync", {4'h0, syncCtl}, 8'h00);
      chk("resync", 8'(nRes), 8'h02);
      wr(IDX_MSK1, 8'h80);
      pulse(15'h2000, 1);
      chk("intn", {7'h00, intN}, 8'h01);
      pulse(15'h4000, 1);
      chk("intn", {7'h00, intN}, 8'h00);
      rd(IDX_SUM, 8'h01, "sum");
      rd(IDX_LS1, 8'hE0, "ls1");
      wr(IDX_LS1, 8'h60);
      rd(IDX_LS1, 8'h80, "ls1");
      wr(IDX_LS1, 8'h80);
      chk("intn", {7'h00, intN}, 8'h01);
      pulse(15'h1000, 15);
      rd(IDX_LS1, 8'h08, "ls1");
      pulse(15'h1000, 1);
      rd(IDX_LS1, 8'h0C, "ls1");
      wr(IDX_LS1, 8'hFF);
      wr(IDX_MODE, 8'h09);
      run <= 1'b0;
      repeat (120) @(posedge clk);
      rd(IDX_LS1, 8'h01, "loss");
      wr(IDX_LS1, 8'h01);
      rd(IDX_LS1, 8'h00, "loss");
      chk("pin", {7'h00, pin}, 8'h01);
      run <= 1'b1;
      repeat (40) @(posedge clk);
      rd(IDX_LS1, 8'h02, "back");
      chk("pin", {7'h00, pin}, 8'h00);
      ev.fifoLevel <= FIFO_DEPTH;
      repeat (3) @(posedge clk);
      ev.fifoLevel <= FIFO_DEPTH - 7'h01;
      repeat (3) @(posedge clk);
      rd(IDX_LS2, 8'h01, "nf");
      for (int k = 0; k < 4; k++) begin
         wr(IDX_WMARK, 8'(k));
         ev.fifoLevel <= thr[k];
         wr(IDX_LS2, 8'h1F);
         ev.fifoLevel <= thr[k] - 7'h01;
         repeat (3) @(posedge clk);
         rd(IDX_LS2, 8'h02, "lwm");
      end
      wr(IDX_LS2, 8'h1F);
      pulse(15'h0400, 1);
      chk("abort", 8'(nAbort), 8'h01);
      ev.endMarked <= 1'b1;
      pulse(15'h0500, 1);
      chk("abort", 8'(nAbort), 8'h01);
      rd(IDX_LS2, 8'h0C, "ls2");
      // Sync search latches bit 0 and shows bit 1 live; only the sync mask lets it through.
      wr(IDX_SYNC, 8'h04);
      wr(IDX_MSK3, 8'h01);
      ev.syncSearching <= 1'b1;
      repeat (3) @(posedge clk);
      rd(IDX_LS3, 8'h03, "ls3");
      rd(IDX_SUM, 8'h04, "sum");
      ev.syncSearching <= 1'b0;
      wr(IDX_LS3, 8'h01);
      rd(IDX_LS3, 8'h00, "ls3");
      // T1 with ESF and SLC-96 events; the SLC counter already holds 16 frames from the E1 run.
      wr(IDX_MODE, 8'h06);
      wr(IDX_MSK2, 8'h10);
      wr(IDX_LS1, 8'hFF);
      rd(IDX_SUM, 8'h00, "sum");
      pulse(15'h0800, 1);
      rd(IDX_SUM, 8'h02, "sum");
      chk("intn", {7'h00, intN}, 8'h00);
      pulse(15'h1000, 23);
      rd(IDX_LS1, 8'h00, "ls1");
      pulse(15'h1000, 1);
      rd(IDX_LS1, 8'h04, "ls1");
      wr(IDX_LS1, 8'hFF);
      pulse(15'h1000, 32);
      rd(IDX_LS1, 8'h14, "ls1");
      print_verdict();
   end
endmodule : tx_status_interrupt_regs_tb
`default_nettype wire
